/* File: slt_pins.sv */
// Pin source model: trigger button and supply monitor.
`timescale 1ns/10ps
module slt_pins (
  // Clock
  input  wire logic sys_clk_i,
  // Requested levels
  input  wire logic trg_req_i,
  input  wire logic pf_req_i,
  // Pin levels
  output logic      trg_o = 1'b0,
  output logic      pf_o  = 1'b0
);
  // Pins move one edge after the request, as a slow outside source would.
  always @(posedge sys_clk_i) begin
    trg_o <= trg_req_i;
    pf_o  <= pf_req_i;
  end
endmodule // slt_pins

/* File: slt_regs.vh */
// Register offsets, field positions, reset values and timing constants of the stair light timer.
`ifndef SLT_REGS_VH
`define SLT_REGS_VH

// ****************************************
// Register offsets
// ****************************************
`define SLT_OFF_CTRL    8'h00
`define SLT_OFF_TDELAY  8'h04
`define SLT_OFF_WSTART  8'h08
`define SLT_OFF_WLEN    8'h0c
`define SLT_OFF_ELAPSED 8'h10
`define SLT_OFF_STATUS  8'h14

// ****************************************
// Field positions
// ****************************************
`define SLT_CTRL_RET    0
`define SLT_CTRL_WARN   1
`define SLT_CTRL_TB_LO  2
`define SLT_CTRL_TB_HI  3
`define SLT_CTRL_SRC_T  4
`define SLT_CTRL_SRC_WS 5
`define SLT_CTRL_SRC_WL 6
`define SLT_CTRL_W      7
`define SLT_ST_Q        0
`define SLT_ST_ON       1
`define SLT_ST_WARN     2
`define SLT_ST_PF       3

// Retention codes: the "/" setting and the "R" setting.
`define SLT_RET_NONE    1'b0
`define SLT_RET_KEEP    1'b1

// ****************************************
// Reset values
// ****************************************
`define SLT_RST_CTRL    7'h00
`define SLT_RST_TDELAY  16'h0064
`define SLT_RST_WSTART  16'h000a
`define SLT_RST_WLEN    16'h0002

// ****************************************
// Timing
// ****************************************
`define SLT_CLK_PERIOD_NS 5
`define SLT_BASE_TIME_NS  10000000
`define SLT_BASE_CYC      (`SLT_BASE_TIME_NS / `SLT_CLK_PERIOD_NS)
`define SLT_TB_DIV_10MS   20'h00001
`define SLT_TB_DIV_1S     20'h00064
`define SLT_TB_DIV_1MIN   20'h01770
`define SLT_TB_DIV_1H     20'h57e40

`endif

/* File: slt_sync.v */
// Three-stage input synchroniser with a two-stage agreement filter.
`timescale 1ns/10ps
module slt_sync #(
  parameter W = 2
) (
  // Clock and reset
  input  wire         sys_clk_i,
  input  wire         sys_rst_i,
  // Raw and filtered levels
  input  wire [W-1:0] async_i,
  output wire [W-1:0] level_o
);

  reg [W-1:0] s1_ff;
  reg [W-1:0] s2_ff;
  reg [W-1:0] s3_ff;
  reg [W-1:0] lvl_ff;

  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
          s1_ff[g]  <= 1'b0;
          s2_ff[g]  <= 1'b0;
          s3_ff[g]  <= 1'b0;
          lvl_ff[g] <= 1'b0;
        end else begin
          s1_ff[g] <= async_i[g];
          s2_ff[g] <= s1_ff[g];
          s3_ff[g] <= s2_ff[g];
          // A change counts only once two later stages agree.
          if (s2_ff[g] == s3_ff[g]) begin
            lvl_ff[g] <= s3_ff[g];
          end
        end
      end
    end
  endgenerate

  assign level_o = lvl_ff;

endmodule // slt_sync

/* File: slt_tbase.v */
// Timebase divider giving a one-cycle tick at the selected time unit.
`timescale 1ns/10ps
`include "slt_regs.vh"
module slt_tbase #(
  parameter [31:0] BASE_CYC = `SLT_BASE_CYC
) (
  // Clock and reset
  input  wire       sys_clk_i,
  input  wire       sys_rst_i,
  // Unit select and tick
  input  wire [1:0] sel_i,
  output wire       tick_o
);

  reg  [31:0] pre_ff;
  reg  [19:0] div_ff;
  reg         tick_ff;
  reg  [19:0] ratio;
  wire        base_tick;

  assign base_tick = (pre_ff == BASE_CYC - 32'h1);

  always @* begin
    case (sel_i)
      2'h0:    ratio = `SLT_TB_DIV_10MS;
      2'h1:    ratio = `SLT_TB_DIV_1S;
      2'h2:    ratio = `SLT_TB_DIV_1MIN;
      default: ratio = `SLT_TB_DIV_1H;
    endcase
  end

  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      pre_ff  <= 32'h0;
      div_ff  <= 20'h0;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= 1'b0;
      if (base_tick) begin
        pre_ff <= 32'h0;
        // Compare with >= so a smaller ratio selected on the fly wraps at the next base tick.
        if (div_ff >= ratio - 20'h1) begin
          div_ff  <= 20'h0;
          tick_ff <= 1'b1;
        end else begin
          div_ff <= div_ff + 20'h1;
        end
      end else begin
        pre_ff <= pre_ff + 32'h1;
      end
    end
  end

  assign tick_o = tick_ff;

endmodule // slt_tbase

/* File: slt_timer.v */
// Retriggerable stair light off-delay timer with pre-warning and retention.
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "slt_regs.vh"

module slt_timer #(
  parameter        TW       = 16,
  parameter [31:0] TICK_CYC = `SLT_BASE_CYC
) (
  // Clock and reset
  input  wire          sys_clk_i,
  input  wire          sys_rst_i,
  // Pins
  input  wire          trg_i,
  input  wire          pwr_fail_i,
  // Actual value of another block
  input  wire [TW-1:0] ext_val_i,
  // Register port
  input  wire [7:0]    addr_i,
  input  wire [31:0]   wdata_i,
  input  wire          wr_i,
  input  wire          rd_i,
  output wire [31:0]   rdata_o,
  // Load side
  output wire          q_o,
  output wire          warn_o,
  output wire [TW-1:0] elapsed_time_o
);

  // ****************************************
  // Declarations
  // ****************************************
  reg  [`SLT_CTRL_W-1:0] ctrl_ff;
  reg  [TW-1:0]          tdelay_ff;
  reg  [TW-1:0]          wstart_ff;
  reg  [TW-1:0]          wlen_ff;
  reg  [31:0]            rdata_ff;
  reg                    trg_d_ff;
  reg                    pf_d_ff;
  reg                    on_ff;
  reg  [TW-1:0]          el_ff;
  reg                    q_ff;
  reg                    warn_ff;
  reg                    snap_on_ff;
  reg  [TW-1:0]          snap_el_ff;
  reg                    nxt_on;
  reg  [TW-1:0]          nxt_el;
  reg                    nxt_warn;
  reg  [31:0]            nxt_rdata;
  wire [1:0]             lvl;
  wire                   trg_lvl;
  wire                   pf_lvl;
  wire                   tick;
  wire                   trg_rise;
  wire                   trg_fall;
  wire                   pf_rise;
  wire                   pf_fall;
  wire                   retain;
  wire [TW-1:0]          eff_t;
  wire [TW-1:0]          eff_ws;
  wire [TW-1:0]          eff_wl;
  wire [TW-1:0]          wbeg;
  wire                   expire;
  wire [TW-1:0]          el_max;

  // ****************************************
  // Input capture and timebase
  // ****************************************
  slt_sync #(
    .W (2)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .async_i   ({pwr_fail_i, trg_i}),
    .level_o   (lvl)
  );

  assign trg_lvl = lvl[0];
  assign pf_lvl  = lvl[1];

  slt_tbase #(
    .BASE_CYC (TICK_CYC)
  ) u_tbase (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .sel_i     (ctrl_ff[`SLT_CTRL_TB_HI:`SLT_CTRL_TB_LO]),
    .tick_o    (tick)
  );

  assign trg_rise = trg_lvl & ~trg_d_ff;
  assign trg_fall = ~trg_lvl & trg_d_ff;
  assign pf_rise  = pf_lvl & ~pf_d_ff;
  assign pf_fall  = ~pf_lvl & pf_d_ff;

  // ****************************************
  // Effective parameters
  // ****************************************
  // retention code
  assign retain = (ctrl_ff[`SLT_CTRL_RET] == `SLT_RET_KEEP);

  assign eff_t  = ctrl_ff[`SLT_CTRL_SRC_T]  ? ext_val_i : tdelay_ff;
  assign eff_ws = ctrl_ff[`SLT_CTRL_SRC_WS] ? ext_val_i : wstart_ff;
  assign eff_wl = ctrl_ff[`SLT_CTRL_SRC_WL] ? ext_val_i : wlen_ff;

  // one shared unit
  // A start offset larger than the delay is clamped so the warning begins at zero.
  assign wbeg   = (eff_ws > eff_t) ? {TW{1'b0}} : (eff_t - eff_ws);

  assign expire = on_ff & (el_ff == eff_t);
  assign el_max = {TW{1'b1}};

  // ****************************************
  // Timer state
  // ****************************************
  always @* begin
    nxt_on = on_ff;
    nxt_el = el_ff;
    if (pf_rise) begin
      // Working state is lost while power is down; the snapshot keeps it.
      nxt_on = 1'b0;
      nxt_el = {TW{1'b0}};
    end else if (pf_lvl) begin
      nxt_on = 1'b0;
      nxt_el = {TW{1'b0}};
    end else if (pf_fall) begin
      if (retain) begin
        nxt_on = snap_on_ff;
        nxt_el = snap_el_ff;
      end else begin
        nxt_on = 1'b0;
        nxt_el = {TW{1'b0}};
      end
    end else if (on_ff & (trg_rise | trg_fall)) begin
      nxt_on = 1'b1;
      nxt_el = {TW{1'b0}};
    end else if (trg_rise) begin
      nxt_on = 1'b1;
      nxt_el = {TW{1'b0}};
    end else if (expire) begin
      nxt_on = 1'b0;
    end else if (on_ff & tick & (el_ff != el_max)) begin
      nxt_el = el_ff + {{(TW-1){1'b0}}, 1'b1};
    end
    // drop during warning
    // Written inline so that a change of the warning setting alone re-runs this process.
    nxt_warn = ctrl_ff[`SLT_CTRL_WARN] & nxt_on & (nxt_el >= wbeg) &
               ((nxt_el - wbeg) < eff_wl);
  end

  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      trg_d_ff   <= 1'b0;
      pf_d_ff    <= 1'b0;
      on_ff      <= 1'b0;
      el_ff      <= {TW{1'b0}};
      q_ff       <= 1'b0;
      warn_ff    <= 1'b0;
      snap_on_ff <= 1'b0;
      snap_el_ff <= {TW{1'b0}};
    end else begin
      trg_d_ff <= trg_lvl;
      pf_d_ff  <= pf_lvl;
      on_ff    <= nxt_on;
      el_ff    <= nxt_el;
      warn_ff  <= nxt_warn;
      q_ff     <= nxt_on & ~nxt_warn;
      if (pf_rise) begin
        snap_on_ff <= on_ff;
        snap_el_ff <= el_ff;
      end
    end
  end

  // ****************************************
  // Register port
  // ****************************************
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ctrl_ff   <= `SLT_RST_CTRL;
      tdelay_ff <= `SLT_RST_TDELAY;
      wstart_ff <= `SLT_RST_WSTART;
      wlen_ff   <= `SLT_RST_WLEN;
    end else if (wr_i) begin
      case (addr_i)
        `SLT_OFF_CTRL:   ctrl_ff   <= wdata_i[`SLT_CTRL_W-1:0];
        `SLT_OFF_TDELAY: tdelay_ff <= wdata_i[TW-1:0];
        `SLT_OFF_WSTART: wstart_ff <= wdata_i[TW-1:0];
        `SLT_OFF_WLEN:   wlen_ff   <= wdata_i[TW-1:0];
        default: begin
        end
      endcase
    end
  end

  always @* begin
    nxt_rdata = 32'h0;
    if (rd_i) begin
      case (addr_i)
        `SLT_OFF_CTRL:    nxt_rdata[`SLT_CTRL_W-1:0] = ctrl_ff;
        `SLT_OFF_TDELAY:  nxt_rdata[TW-1:0] = tdelay_ff;
        `SLT_OFF_WSTART:  nxt_rdata[TW-1:0] = wstart_ff;
        `SLT_OFF_WLEN:    nxt_rdata[TW-1:0] = wlen_ff;
        `SLT_OFF_ELAPSED: nxt_rdata[TW-1:0] = el_ff;
        `SLT_OFF_STATUS: begin
          nxt_rdata[`SLT_ST_Q]    = q_ff;
          nxt_rdata[`SLT_ST_ON]   = on_ff;
          nxt_rdata[`SLT_ST_WARN] = warn_ff;
          nxt_rdata[`SLT_ST_PF]   = pf_lvl;
        end
        default: nxt_rdata = 32'h0;
      endcase
    end
  end

  // Read data stand in the cycle after each cycle of rd_i and are zero otherwise.
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      rdata_ff <= 32'h0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign rdata_o        = rdata_ff;
  assign q_o            = q_ff;
  assign warn_o         = warn_ff;
  assign elapsed_time_o = el_ff;

endmodule // slt_timer

/* File: slt_timer_chk.sv */
// Port checker of the stair light timer.
`timescale 1ns/10ps
`include "slt_regs.vh"
module slt_timer_chk #(
  parameter        TW       = 16,
  parameter [31:0] TICK_CYC = 32'd4
) (
  // Clock and reset
  input wire          sys_clk_i,
  input wire          sys_rst_i,
  // Pins
  input wire          trg_i,
  input wire          pwr_fail_i,
  input wire [TW-1:0] ext_val_i,
  // Registers
  input wire [7:0]    addr_i,
  input wire [31:0]   wdata_i,
  input wire          wr_i,
  input wire          rd_i,
  input wire [31:0]   rdata_o,
  // Load
  input wire          q_o,
  input wire          warn_o,
  input wire [TW-1:0] elapsed_time_o
);
  reg  [6:0]    ctrl_ff;
  reg  [TW-1:0] tdel_ff;
  reg  [TW-1:0] wst_ff;
  reg  [2:0]    age_ff;
  reg           trg_ff;
  reg           pf_ff;
  wire [TW:0]   t_eff = {1'b0, ctrl_ff[4] ? ext_val_i : tdel_ff};
  wire [TW:0]   w_eff = {1'b0, ctrl_ff[5] ? ext_val_i : wst_ff};
  wire          on    = q_o | warn_o;
  // Seven still cycles outlast the pin filter, so no restart is in flight.
  wire          quiet = age_ff == 3'd7;
  always @(posedge sys_clk_i) begin
    trg_ff <= trg_i;
    pf_ff  <= pwr_fail_i;
    if (sys_rst_i) begin
      ctrl_ff <= `SLT_RST_CTRL;
      tdel_ff <= `SLT_RST_TDELAY;
      wst_ff  <= `SLT_RST_WSTART;
      age_ff  <= 3'd0;
    end else begin
      if (wr_i && addr_i == `SLT_OFF_CTRL) ctrl_ff <= wdata_i[6:0];
      if (wr_i && addr_i == `SLT_OFF_TDELAY) tdel_ff <= wdata_i[TW-1:0];
      if (wr_i && addr_i == `SLT_OFF_WSTART) wst_ff <= wdata_i[TW-1:0];
      if (trg_i != trg_ff || pwr_fail_i != pf_ff) age_ff <= 3'd0;
      else if (!quiet) age_ff <= age_ff + 3'd1;
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_rise;
    $rose(trg_i) && !on && !pwr_fail_i ##1 (trg_i && !pwr_fail_i) [*4];
  endsequence
  sequence s_edge;
    $changed(trg_i) && on && !pwr_fail_i && elapsed_time_o + 8 < t_eff
      ##1 ($stable(trg_i) && !pwr_fail_i) [*4];
  endsequence
  sequence s_back;
    $fell(pwr_fail_i) && !ctrl_ff[0] && $stable(trg_i)
      ##1 (!pwr_fail_i && $stable(trg_i)) [*4];
  endsequence
  a_rise_sets: assert property (s_rise |-> ##1 on && elapsed_time_o == '0)
    else $error("rise did not switch on");
  a_edge_restart: assert property (s_edge |-> ##1 on && elapsed_time_o == '0)
    else $error("edge did not restart");
  a_expiry_off: assert property (quiet && on && elapsed_time_o == t_eff |=> !on)
    else $error("on after expiry");
  a_count_step: assert property (quiet && on |=> elapsed_time_o - $past(elapsed_time_o) <= 1)
    else $error("bad count step");
  a_warn_low: assert property (warn_o |-> !q_o)
    else $error("on during warning");
  a_warn_win: assert property (warn_o |-> ctrl_ff[1] && elapsed_time_o + w_eff >= t_eff)
    else $error("warning out of window");
  a_pf_clear: assert property (pwr_fail_i [*6] |-> !on)
    else $error("on during power loss");
  a_pf_dflt: assert property (s_back |-> ##1 !on && elapsed_time_o == '0)
    else $error("state kept without retention");
endmodule // slt_timer_chk
bind slt_timer slt_timer_chk #(.TW(TW), .TICK_CYC(TICK_CYC)) u_chk (
  .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .trg_i(trg_i), .pwr_fail_i(pwr_fail_i),
  .ext_val_i(ext_val_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .q_o(q_o), .warn_o(warn_o), .elapsed_time_o(elapsed_time_o));

/* File: slt_timer_tb.sv */
// Self-checking bench of the stair light timer.
`timescale 1ns/10ps
`include "slt_regs.vh"
module slt_timer_tb;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] x;} slt_row_t;
  logic        sys_clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        trg_req   = 1'b0;
  logic        pf_req    = 1'b0;
  logic [15:0] ext       = 16'h0000;
  logic [7:0]  addr_i    = 8'h00;
  logic [31:0] wdata_i   = 32'h0;
  logic        wr_i      = 1'b0;
  logic        rd_i      = 1'b0;
  logic        trg, pf, q_o, warn_o;
  logic [15:0] el, e0;
  logic [31:0] rdata_o, r;
  int          fail_count = 0;
  int          checked    = 0;
  int          n, w;
  slt_row_t    rows [9] = '{
    '{`SLT_OFF_CTRL, 32'hffffffff, 32'h7f}, '{`SLT_OFF_TDELAY, 32'hffffffff, 32'hffff},
    '{`SLT_OFF_ELAPSED, 32'h1, 32'h0}, '{`SLT_OFF_STATUS, 32'hf, 32'h0},
    '{8'h18, 32'h5, 32'h0}, '{`SLT_OFF_CTRL, 32'h0, 32'h0},
    '{`SLT_OFF_TDELAY, 32'hc, 32'hc}, '{`SLT_OFF_WSTART, 32'h4, 32'h4},
    '{`SLT_OFF_WLEN, 32'h2, 32'h2}};
  slt_pins u_pins (.sys_clk_i(sys_clk_i), .trg_req_i(trg_req), .pf_req_i(pf_req),
    .trg_o(trg), .pf_o(pf));
  slt_timer #(.TW(16), .TICK_CYC(32'd4)) uut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .trg_i(trg), .pwr_fail_i(pf), .ext_val_i(ext), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .q_o(q_o), .warn_o(warn_o),
    .elapsed_time_o(el));
  initial begin
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  task automatic finish_test();
    if (fail_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    cyc(1);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    cyc(1);
    wr_i    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    cyc(1);
    addr_i <= a;
    rd_i   <= 1'b1;
    cyc(1);
    rd_i   <= 1'b0;
    @(negedge sys_clk_i);
    d = rdata_o;
  endtask
  task automatic pulse(input int k);
    cyc(1);
    trg_req <= 1'b1;
    cyc(k);
    trg_req <= 1'b0;
  endtask
  // Counts cycles with the load on or in warning, and those of them in warning.
  task automatic on_len(output int c, output int wc);
    c  = 0;
    wc = 0;
    @(negedge sys_clk_i);
    while ((q_o | warn_o) === 1'b1 && c < 5000) begin
      c++;
      wc += int'(warn_o === 1'b1);
      @(negedge sys_clk_i);
    end
  endtask
  task automatic pf_cycle();
    cyc(1);
    pf_req <= 1'b1;
    cyc(20);
    pf_req <= 1'b0;
    @(negedge sys_clk_i);
    chk({31'h0, q_o}, 32'h0);
    cyc(8);
    @(negedge sys_clk_i);
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    fail_count++;
    finish_test();
  end
  initial begin
    cyc(10);
    sys_rst_i <= 1'b0;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, r);
      chk(r, rows[i].x);
    end
    pulse(20);
    on_len(n, w);
    chk(32'(n >= 50 && n <= 58), 32'h1);
    pulse(20);
    cyc(20);
    pulse(10);
    on_len(n, w);
    chk(32'(n >= 50 && n <= 58), 32'h1);
    wr(`SLT_OFF_CTRL, 32'h2);
    pulse(10);
    on_len(n, w);
    chk(32'(w), 32'h8);
    chk(32'(n >= 50 && n <= 58), 32'h1);
    cyc(1);
    ext <= 16'h0002;
    wr(`SLT_OFF_CTRL, 32'h14);
    pulse(10);
    on_len(n, w);
    chk(32'(n >= 405 && n <= 812), 32'h1);
    wr(`SLT_OFF_CTRL, 32'h1);
    cyc(1);
    trg_req <= 1'b1;
    cyc(20);
    @(negedge sys_clk_i);
    e0 = el;
    pf_cycle();
    chk(32'(q_o === 1'b1 && el >= e0 && el <= e0 + 16'h4), 32'h1);
    rd(`SLT_OFF_STATUS, r);
    chk(r, 32'h3);
    wr(`SLT_OFF_CTRL, 32'h0);
    pf_cycle();
    chk({15'h0, q_o, el}, 32'h0);
    cyc(1);
    trg_req <= 1'b0;
    cyc(8);
    @(negedge sys_clk_i);
    chk({31'h0, q_o}, 32'h0);
    cyc(1);
    sys_rst_i <= 1'b1;
    cyc(2);
    sys_rst_i <= 1'b0;
    rd(`SLT_OFF_CTRL, r);
    chk(r, 32'h0);
    rd(`SLT_OFF_TDELAY, r);
    chk(r, {16'h0, `SLT_RST_TDELAY});
    rd(`SLT_OFF_WSTART, r);
    chk(r, {16'h0, `SLT_RST_WSTART});
    rd(`SLT_OFF_WLEN, r);
    chk(r, {16'h0, `SLT_RST_WLEN});
    finish_test();
  end
endmodule // slt_timer_tb
